// *** hw/vbsc_top.sv ***
// Oscillator select, band search and control registers
//
// Function
// R1: Route one of three oscillators, chosen by osc_select.
// R2: Each oscillator has 128 coarse bands, seven-bit band code.
// R3: Search targets the frequency value programmed in the bank.
// R4: Every enable pin rise starts a search if search is enabled.
// R5: Loop locking is enabled only after the band is fixed.
// R6: Capacitance steps are added one by one until near target.
// R7: Chosen band code is placed in the read-back register.
// R8: Final code 0 or 127 marks a failed search.
// R9: Final codes 1 to 126 mark a successful search.
// R10: Search takes about 1500 phase detector clock cycles.
// R11: Host should rerun the search every thirty degrees.
// R12: Host may copy result to default band, then disable search.
// R13: LO output is oscillator divided by two or four.
// R14: Oscillator core current follows its control word.
// R15: Host should set LO buffer current to 1100 above 2 GHz.
// R16: Reference bypass passes through, else divide by two to seven.
// R17: With search disabled, enable rise applies the default band.
`timescale 1ns/1ns
`include "vbsc_cfg.svh"
module vbsc_top #(
  parameter int TGT_W = 16,
  parameter int CUR_W = 4
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // Avalon-MM slave
  input  wire logic [5:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // Pins and analog side ticks
  input  wire logic             chip_enable_pin_i,
  input  wire logic             ref_tick_i,
  input  wire logic             osc_tick_i,
  // Oscillator control
  output logic      [2:0]       osc_en_o,
  output logic      [6:0]       band_code_o,
  output logic      [CUR_W-1:0] osc_core_current_o,
  output logic      [3:0]       lo_buffer_current_o,
  output logic                  lo_o,
  output logic                  loop_lock_en_o,
  // Interrupt
  output logic                  irq_o
);
  localparam int BANDS = `VBSC_BAND_COUNT;
  localparam int WIN_TICKS = `VBSC_SEARCH_CYC / BANDS;
  // Reset words kept whole so each field is a plain bit-select
  localparam logic [31:0] CTRL_RST   = `VBSC_CTRL_RST;
  localparam logic [3:0]  REFDIV_RST = `VBSC_REFDIV_RST;

  if (TGT_W < 8 || TGT_W > 24 || CUR_W < 1 || CUR_W > 4) begin : g_chk
    $error("vbsc_top: unsupported parameter values");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [1:0]       osc_select;
  logic             band_search_enable;
  logic             lo_divide_select;
  logic [6:0]       default_band_code;
  logic [TGT_W-1:0] target;
  logic             ref_divider_bypass;
  logic [2:0]       ref_div_value;
  logic [6:0]       band_result_code;
  logic [1:0]       irq_sts;
  logic [1:0]       irq_en;
  logic             ack;
  logic             wr_go;

  vbsc_pkg::vbsc_state_t state;
  logic [6:0]       band;
  logic [TGT_W-1:0] cnt;
  logic [7:0]       win;
  logic             en_q;
  logic             en_rise;
  logic             pd_tick;
  logic             done;
  logic             fail_now;
  logic             res_fail;

  // One wait state: the answer always comes on the second cycle
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  assign wr_go = avs_write_i && ack;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      osc_select          <= 2'h0;
      band_search_enable  <= CTRL_RST[`VBSC_CTRL_SRCH];
      lo_divide_select    <= 1'b0;
      lo_buffer_current_o <= 4'h0;
      osc_core_current_o  <= '0;
      default_band_code   <= `VBSC_DEFBAND_RST;
      target              <= TGT_W'(`VBSC_TARGET_RST);
      ref_divider_bypass  <= REFDIV_RST[0];
      ref_div_value       <= REFDIV_RST[3:1];
      irq_en              <= 2'h0;
    end else if (wr_go) begin
      case (avs_address_i)
        `VBSC_OFS_CTRL: begin
          osc_select <= avs_writedata_i[`VBSC_CTRL_SEL_LSB +: 2];
          band_search_enable <= avs_writedata_i[`VBSC_CTRL_SRCH]; // R12
          lo_divide_select <= avs_writedata_i[`VBSC_CTRL_DIV4];
          lo_buffer_current_o <= avs_writedata_i[`VBSC_CTRL_BUF_LSB +: 4];
          osc_core_current_o <=
            avs_writedata_i[`VBSC_CTRL_CUR_LSB +: CUR_W]; // R14
        end
        `VBSC_OFS_DEFBAND: default_band_code <= avs_writedata_i[6:0];
        `VBSC_OFS_TARGET:  target <= avs_writedata_i[TGT_W-1:0];
        `VBSC_OFS_REFDIV: begin
          ref_divider_bypass <= avs_writedata_i[0];
          ref_div_value      <= avs_writedata_i[3:1];
        end
        `VBSC_OFS_IRQEN:   irq_en <= avs_writedata_i[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !ack) begin
      case (avs_address_i)
        `VBSC_OFS_CTRL: avs_readdata_o <=
          (32'(osc_select) << `VBSC_CTRL_SEL_LSB) |
          (32'(band_search_enable) << `VBSC_CTRL_SRCH) |
          (32'(lo_divide_select) << `VBSC_CTRL_DIV4) |
          (32'(lo_buffer_current_o) << `VBSC_CTRL_BUF_LSB) |
          (32'(osc_core_current_o) << `VBSC_CTRL_CUR_LSB);
        `VBSC_OFS_DEFBAND: avs_readdata_o <= 32'(default_band_code);
        `VBSC_OFS_TARGET:  avs_readdata_o <= 32'(target);
        `VBSC_OFS_REFDIV:
          avs_readdata_o <= 32'({ref_div_value, ref_divider_bypass});
        `VBSC_OFS_RDBACK: avs_readdata_o <= 32'(band_result_code) |
          (32'(res_fail) << `VBSC_RB_FAIL) |
          (32'(state != vbsc_pkg::VBSC_IDLE) << `VBSC_RB_BUSY) |
          (32'(loop_lock_en_o) << `VBSC_RB_LOCK); // R7
        `VBSC_OFS_IRQSTS:  avs_readdata_o <= 32'(irq_sts);
        `VBSC_OFS_IRQEN:   avs_readdata_o <= 32'(irq_en);
        default:           avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------------
  vbsc_ref_div u_ref_div (
    .clk_sys_i            (clk_sys_i),
    .rst_i                (rst_i),
    .ref_divider_bypass_i (ref_divider_bypass),
    .ref_div_value_i      (ref_div_value),
    .ref_tick_i           (ref_tick_i),
    .pd_tick_o            (pd_tick)
  );

  vbsc_lo_div u_lo_div (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .div4_i     (lo_divide_select),
    .osc_tick_i (osc_tick_i),
    .lo_o       (lo_o)
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      osc_en_o <= 3'h0;
    end else begin
      // Code three has no fourth oscillator, so it falls back to the third
      case (osc_select)
        2'h0:    osc_en_o <= 3'h1; // R1
        2'h1:    osc_en_o <= 3'h2; // R1
        default: osc_en_o <= 3'h4; // R1
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Band search
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= chip_enable_pin_i;
    end
  end

  assign en_rise = chip_enable_pin_i && !en_q;
  assign done = (state == vbsc_pkg::VBSC_EVAL) &&
                (cnt <= target || band == `VBSC_BAND_MAX); // R6
  assign fail_now = band == `VBSC_BAND_MIN ||
                    band == `VBSC_BAND_MAX; // R8

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= vbsc_pkg::VBSC_IDLE;
      band  <= `VBSC_BAND_MIN;
      cnt   <= '0;
      win   <= 8'h0;
    end else if (!chip_enable_pin_i) begin
      state <= vbsc_pkg::VBSC_IDLE;
    end else if (en_rise) begin
      cnt <= '0;
      win <= 8'h0;
      if (band_search_enable) begin
        band  <= `VBSC_BAND_MIN; // R4
        state <= vbsc_pkg::VBSC_COUNT; // R4
      end else begin
        band  <= default_band_code; // R17
        state <= vbsc_pkg::VBSC_IDLE;
      end
    end else begin
      case (state)
        vbsc_pkg::VBSC_COUNT: begin
          if (osc_tick_i && cnt != '1) begin
            cnt <= cnt + 1'b1;
          end
          // Window length spreads the whole sweep over the search time
          if (pd_tick) begin
            if (win == 8'(WIN_TICKS - 1)) begin // R10
              state <= vbsc_pkg::VBSC_EVAL;
            end else begin
              win <= win + 8'h1;
            end
          end
        end
        vbsc_pkg::VBSC_EVAL: begin
          if (done) begin // R3
            state <= vbsc_pkg::VBSC_IDLE;
          end else begin
            band  <= band + 7'h1; // R6
            cnt   <= '0;
            win   <= 8'h0;
            state <= vbsc_pkg::VBSC_COUNT;
          end
        end
        default: state <= vbsc_pkg::VBSC_IDLE;
      endcase
    end
  end

  assign band_code_o = band; // R2

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      band_result_code <= `VBSC_BAND_MIN;
      res_fail         <= 1'b0;
    end else if (done) begin
      band_result_code <= band; // R7
      res_fail         <= fail_now; // R8 R9
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      loop_lock_en_o <= 1'b0;
    end else if (!chip_enable_pin_i) begin
      loop_lock_en_o <= 1'b0;
    end else if (en_rise) begin
      loop_lock_en_o <= !band_search_enable; // R17
    end else if (done) begin
      loop_lock_en_o <= 1'b1; // R5
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_sts <= 2'h0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_sts <= (irq_sts &
                  ~((wr_go && avs_address_i == `VBSC_OFS_IRQCLR) ?
                    avs_writedata_i[1:0] : 2'h0)) |
                 {done && fail_now, done};
    end
  end

  assign irq_o = |(irq_sts & irq_en);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_lock_waits_band: assert property (
    state != vbsc_pkg::VBSC_IDLE |-> !loop_lock_en_o) // R5
    else $error("loop locking enabled during search");

  a_fail_extremes: assert property (
    done && fail_now |=> res_fail && irq_sts[`VBSC_IRQ_FAIL]) // R8
    else $error("extreme band not flagged as failure");

  a_success_codes: assert property (
    done && !fail_now |=> !res_fail &&
      band_result_code == $past(band)) // R9
    else $error("good band not reported");

  a_search_start: assert property (
    en_rise && band_search_enable |=>
      state == vbsc_pkg::VBSC_COUNT && band == `VBSC_BAND_MIN) // R4
    else $error("enable rise did not start search");

  a_default_apply: assert property (
    en_rise && !band_search_enable |=>
      band_code_o == $past(default_band_code) && loop_lock_en_o) // R17
    else $error("default band not applied");

  a_band_step: assert property (
    state == vbsc_pkg::VBSC_EVAL && !done && chip_enable_pin_i |=>
      band == $past(band) + 7'h1) // R6
    else $error("band did not advance by one");

  a_osc_route: assert property (
    $changed(osc_select) |=> $onehot(osc_en_o) &&
      (osc_select == 2'h3 || osc_en_o[osc_select])) // R1
    else $error("wrong oscillator routed");

  a_result_shown: assert property (
    avs_read_i && !ack && avs_address_i == `VBSC_OFS_RDBACK
      |=> avs_readdata_o[6:0] == $past(band_result_code)) // R7
    else $error("read-back field stale");

  c_search_ok: cover property (done && !fail_now);
  c_search_fail: cover property (done && fail_now);
  c_default_band: cover property (en_rise && !band_search_enable);
  c_irq_raised: cover property ($rose(irq_o));
endmodule

// *** include/vbsc_cfg.svh ***
// Register map, field positions, reset values and timing for band select
`ifndef VBSC_CFG_SVH
`define VBSC_CFG_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define VBSC_OFS_CTRL    6'h00
`define VBSC_OFS_DEFBAND 6'h04
`define VBSC_OFS_TARGET  6'h08
`define VBSC_OFS_REFDIV  6'h0C
`define VBSC_OFS_RDBACK  6'h10
`define VBSC_OFS_IRQSTS  6'h14
`define VBSC_OFS_IRQCLR  6'h18
`define VBSC_OFS_IRQEN   6'h1C
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define VBSC_CTRL_SEL_LSB  0
`define VBSC_CTRL_SRCH    2
`define VBSC_CTRL_DIV4    3
`define VBSC_CTRL_BUF_LSB 4
`define VBSC_CTRL_CUR_LSB 8
`define VBSC_CTRL_RST     32'h0000_0004
`define VBSC_DEFBAND_RST  7'h40
`define VBSC_TARGET_RST   16'h0100
`define VBSC_REFDIV_RST   4'h1
`define VBSC_RB_FAIL      8
`define VBSC_RB_BUSY      9
`define VBSC_RB_LOCK      10
`define VBSC_IRQ_DONE     0
`define VBSC_IRQ_FAIL     1
// ----------------------------------------------------------------------
// Band codes and search timing
// ----------------------------------------------------------------------
`define VBSC_BAND_MIN     7'h00
`define VBSC_BAND_MAX     7'h7F
`define VBSC_SEARCH_CYC   1500
`define VBSC_BAND_COUNT   128
`define VBSC_REFDIV_MIN   3'h2
`endif

// *** include/vbsc_pkg.sv ***
// Types shared by the band select logic
package vbsc_pkg;
  typedef enum logic [1:0] {
    VBSC_IDLE,
    VBSC_COUNT,
    VBSC_EVAL
  } vbsc_state_t;
endpackage

// *** hw/vbsc_ref_div.sv ***
// Reference divider producing the phase detector tick
`timescale 1ns/1ns
`include "vbsc_cfg.svh"
module vbsc_ref_div (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       ref_divider_bypass_i,
  input  wire logic [2:0] ref_div_value_i,
  // Reference in, phase detector tick out
  input  wire logic       ref_tick_i,
  output logic            pd_tick_o
);
  logic [2:0] cnt;
  logic [2:0] lim;

  // Codes below two are treated as divide by two
  always_comb begin
    lim = (ref_div_value_i < `VBSC_REFDIV_MIN) ? `VBSC_REFDIV_MIN
                                              : ref_div_value_i;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 3'h0;
    end else if (ref_tick_i) begin
      if (ref_divider_bypass_i || cnt == lim - 3'h1) begin // R16
        cnt <= 3'h0;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end

  assign pd_tick_o = ref_tick_i &&
                     (ref_divider_bypass_i || cnt == lim - 3'h1); // R16

  a_ref_div_gap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pd_tick_o && !ref_divider_bypass_i |=> !pd_tick_o) // R16
    else $error("divided reference ticked twice in a row");
endmodule

// *** hw/vbsc_lo_div.sv ***
// LO divider, divide by two or four of the oscillator
`timescale 1ns/1ns
module vbsc_lo_div (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Control and oscillator
  input  wire logic div4_i,
  input  wire logic osc_tick_i,
  // LO output
  output logic      lo_o
);
  logic half;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      half <= 1'b0;
      lo_o <= 1'b0;
    end else if (osc_tick_i) begin
      half <= ~half;
      if (!div4_i || half) begin // R13
        lo_o <= ~lo_o;
      end
    end
  end

  a_lo_div_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !div4_i && osc_tick_i |=> lo_o != $past(lo_o)) // R13
    else $error("divide by two missed an oscillator edge");
endmodule

// *** verification/vbsc_osc_model.sv ***
// Oscillator and reference tick model facing the band select block
`timescale 1ns/1ns
module vbsc_osc_model #(
  parameter int REF_PER = 4
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Oscillator control from the block
  input  wire logic [2:0] osc_en_i,
  input  wire logic [6:0] band_code_i,
  // Ticks to the block
  output logic            ref_tick_o,
  output logic            osc_tick_o
);
  logic [7:0] ref_cnt;
  logic [8:0] acc;
  logic [7:0] base;

  // ---------------------------------------------------------------
  // Tank model
  // ---------------------------------------------------------------
  // Each oscillator spans its own range, lowest on the third one
  always_comb begin
    base = osc_en_i[2] ? 8'hBF : (osc_en_i[1] ? 8'hDF : 8'hFF);
  end

  // More band capacitance gives a slower oscillator
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= 9'h000;
    end else begin
      acc <= {1'b0, acc[7:0]} + {1'b0, base - {1'b0, band_code_i}};
    end
  end
  assign osc_tick_o = acc[8];

  // ---------------------------------------------------------------
  // Reference
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt    <= 8'h00;
      ref_tick_o <= 1'b0;
    end else begin
      ref_cnt    <= (ref_cnt == 8'(REF_PER - 1)) ? 8'h00 : ref_cnt + 8'h01;
      ref_tick_o <= (ref_cnt == 8'(REF_PER - 1));
    end
  end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the band select block
`timescale 1ns/1ns
`include "vbsc_cfg.svh"
module testbench;
  localparam int REF_PER = 4;
  localparam int W1      = 11 * REF_PER;
  logic        clk_sys_i;
  logic        rst_i;
  logic [5:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        chip_enable_pin_i;
  logic        ref_tick_i;
  logic        osc_tick_i;
  logic [2:0]  osc_en_o;
  logic [6:0]  band_code_o;
  logic [3:0]  osc_core_current_o;
  logic [3:0]  lo_buffer_current_o;
  logic        lo_o;
  logic        loop_lock_en_o;
  logic        irq_o;
  int          errors;
  int          comparisons;
  int          cycles;
  logic [31:0] r;
  int          sel;
  int          bnd;

  vbsc_top u_vbsc_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .chip_enable_pin_i(chip_enable_pin_i), .ref_tick_i(ref_tick_i),
    .osc_tick_i(osc_tick_i), .osc_en_o(osc_en_o), .band_code_o(band_code_o),
    .osc_core_current_o(osc_core_current_o),
    .lo_buffer_current_o(lo_buffer_current_o), .lo_o(lo_o),
    .loop_lock_en_o(loop_lock_en_o), .irq_o(irq_o));

  vbsc_osc_model #(.REF_PER(REF_PER)) u_vbsc_osc_model (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .osc_en_i(osc_en_o),
    .band_code_i(band_code_o), .ref_tick_o(ref_tick_i),
    .osc_tick_o(osc_tick_i));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Whole run is well under this; a hang ends here
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask

  task automatic rd(logic [5:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask

  function automatic int base_of(int s);
    return (s == 0) ? 255 : ((s == 1) ? 223 : 191);
  endfunction

  // First band whose count over the window is at or below target
  function automatic int exp_band(int base, int tgt, int w);
    for (int b = 0; b < 128; b++) begin
      if ((w * (base - b)) / 256 <= tgt) return b;
    end
    return 127;
  endfunction

  task automatic pin_rise();
    @(posedge clk_sys_i);
    chip_enable_pin_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chip_enable_pin_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask

  // Search with target tgt on oscillator s; window w cycles
  task automatic search(int s, int tgt, int w);
    int          n;
    int          e;
    int          en;
    logic [6:0]  p;
    logic [6:0]  b;
    logic        f;
    e  = exp_band(base_of(s), tgt, w);
    en = $urandom % 4;
    wr(`VBSC_OFS_CTRL, 32'(4 | s));
    wr(`VBSC_OFS_TARGET, 32'(tgt));
    wr(`VBSC_OFS_IRQEN, 32'(en));
    pin_rise();
    chk("lock in search", 0, loop_lock_en_o);
    p = band_code_o;
    n = 0;
    while (loop_lock_en_o !== 1'b1 && n < 40000) begin
      @(posedge clk_sys_i);
      if (band_code_o !== p && band_code_o !== p + 7'h01)
        chk("band step", p + 7'h01, band_code_o);
      p = band_code_o;
      n++;
    end
    b = band_code_o;
    f = (b == 7'h00) || (b == 7'h7F);
    if ((e > b ? e - b : b - e) > 8) chk("band result", e, b);
    rd(`VBSC_OFS_RDBACK, r);
    chk("readback code", b, r[6:0]);
    chk("fail flag", f, r[`VBSC_RB_FAIL]);
    chk("lock flag", 1, r[`VBSC_RB_LOCK]);
    rd(`VBSC_OFS_IRQSTS, r);
    chk("irq status", {f, 1'b1}, r);
    chk("irq level", |(en[1:0] & {f, 1'b1}), irq_o);
    wr(`VBSC_OFS_IRQCLR, 32'h3);
    // Clear lands on the edge that ends the write; look one edge later
    @(posedge clk_sys_i);
    chk("irq cleared", 0, irq_o);
  endtask

  task automatic lo_check(int d4);
    int   t;
    int   l;
    logic p;
    wr(`VBSC_OFS_CTRL, 32'(4 | d4 << 3));
    t = 0;
    l = 0;
    p = lo_o;
    repeat (400) begin
      @(posedge clk_sys_i);
      t += int'(osc_tick_i);
      l += int'(lo_o && !p);
      p = lo_o;
    end
    chk("lo rate", 1, (l * (d4 ? 4 : 2) - t) inside {[-5:5]});
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    avs_address_i = 6'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    chip_enable_pin_i = 1'b0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(86231));
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(`VBSC_OFS_CTRL, r);
    chk("ctrl reset", `VBSC_CTRL_RST, r);
    rd(`VBSC_OFS_DEFBAND, r);
    chk("defband reset", `VBSC_DEFBAND_RST, r);
    rd(`VBSC_OFS_TARGET, r);
    chk("target reset", `VBSC_TARGET_RST, r);
    rd(`VBSC_OFS_REFDIV, r);
    chk("refdiv reset", `VBSC_REFDIV_RST, r);
    wr(`VBSC_OFS_RDBACK, 32'hFFFF_FFFF);
    rd(`VBSC_OFS_RDBACK, r);
    chk("readback read only", 0, r);
    rd(6'h20, r);
    chk("unmapped", 0, r);
    rd(`VBSC_OFS_IRQCLR, r);
    chk("clear reads zero", 0, r);
    for (int s = 0; s < 4; s++) begin
      wr(`VBSC_OFS_CTRL, 32'((s + 5) << 8 | 12 << 4 | 4 | s));
      rd(`VBSC_OFS_CTRL, r);
      chk("ctrl", 32'((s + 5) << 8 | 12 << 4 | 4 | s), r);
      chk("osc enable", s == 0 ? 1 : (s == 1 ? 2 : 4), osc_en_o);
      chk("core current", s + 5, osc_core_current_o);
      chk("buffer current", 12, lo_buffer_current_o);
    end
    lo_check(0);
    lo_check(1);
    search(0, 255, W1);
    search(2, 0, W1);
    repeat (5) begin
      sel = $urandom % 3;
      bnd = 10 + $urandom % 108;
      search(sel, (W1 * (base_of(sel) - bnd)) / 256, W1);
    end
    // Host reruns the search at an unchanged frequency
    repeat (2) search(1, (W1 * 120) / 256, W1);
    wr(`VBSC_OFS_REFDIV, 32'h6);
    search(0, (3 * W1 * 180) / 256, 3 * W1);
    wr(`VBSC_OFS_REFDIV, 32'h1);
    pin_rise();
    repeat (20) @(posedge clk_sys_i);
    chip_enable_pin_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("lock after abort", 0, loop_lock_en_o);
    rd(`VBSC_OFS_RDBACK, r);
    chk("busy after abort", 0, r[`VBSC_RB_BUSY]);
    wr(`VBSC_OFS_DEFBAND, 32'h15);
    wr(`VBSC_OFS_CTRL, 32'h0);
    pin_rise();
    chk("default band", 7'h15, band_code_o);
    chk("lock default", 1, loop_lock_en_o);
    stop_test();
  end
endmodule
